// ---- bench/dsc_codec_sva.sv ----
`timescale 1ns/1ps
module dsc_codec_sva (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Command
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire inline_form,
  input wire [15:0] reg_word0,
  input wire [15:0] reg_word1,
  input wire [15:0] desc_ptr,
  input wire [127:0] res_digits,
  // Memory
  input wire [15:0] mem_addr,
  input wire mem_rd,
  input wire mem_wr,
  input wire mem_word,
  input wire [15:0] mem_wdata,
  // Results
  input wire busy,
  input wire done,
  input wire overflow,
  input wire type_bad,
  input wire [4:0] desc_len,
  input wire [2:0] desc_type
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wire take = cmd_valid && !busy;
  wire bacc = mem_wr || (mem_rd && !mem_word);
  reg [4:0] cnt_r;
  reg st_r;
  reg rf_r;
  reg [15:0] w0_r;
  reg [15:0] w1_r;
  reg [15:0] p_r;
  reg [7:0] sb_r;
  // Byte accesses are counted per command; descriptor word reads are not.
  always @(posedge clk_sys) begin
    if (take) begin
      cnt_r <= 5'h0;
      st_r <= cmd_op == 2'h1;
      rf_r <= !inline_form;
      w0_r <= reg_word0;
      w1_r <= reg_word1;
      p_r <= desc_ptr;
    end else if (bacc) begin
      cnt_r <= cnt_r + 5'h1;
    end
    if (mem_wr) begin
      sb_r <= mem_wdata[7:0];
    end
  end
  property p_r10;
    take && inline_form |-> ##1 (mem_rd && mem_word && mem_addr == p_r)
      ##[1:3] (mem_rd && mem_word && mem_addr == p_r + 16'h2);
  endproperty
  a_r10: assert property (p_r10) else $error("descriptor fetch wrong");
  property p_r11;
    done && rf_r |-> desc_len == w0_r[4:0] && desc_type == w0_r[14:12];
  endproperty
  a_r11: assert property (p_r11) else $error("descriptor fields wrong");
  property p_r12;
    bacc && cnt_r == 5'h0 && rf_r |-> mem_addr == w1_r;
  endproperty
  a_r12: assert property (p_r12) else $error("first byte address wrong");
  property p_r15;
    done |-> type_bad == (desc_type[2:1] != 2'b11);
  endproperty
  a_r15: assert property (p_r15) else $error("type flag wrong");
  property p_r21;
    done && !type_bad |-> cnt_r == desc_len / 2 + 1;
  endproperty
  a_r21: assert property (p_r21) else $error("byte count wrong");
  property p_r17;
    done && st_r && !type_bad |-> (desc_type[0] ? sb_r[3:0] == 4'hf
      : (sb_r[3:0] == 4'hc || sb_r[3:0] == 4'hd));
  endproperty
  a_r17: assert property (p_r17) else $error("sign nibble wrong");
  property p_r6;
    done && st_r |-> overflow == ((res_digits >> {desc_len, 2'b00}) != 128'h0);
  endproperty
  a_r6: assert property (p_r6) else $error("overflow wrong");
  property p_r20;
    mem_wr && cnt_r == 5'h0 && rf_r && !w0_r[0] |-> mem_wdata[7:4] == 4'h0;
  endproperty
  a_r20: assert property (p_r20) else $error("even top nibble not zero");
  c_inl: cover property (take && inline_form && cmd_op == 2'h1);
  c_ovf: cover property (done && overflow);
  c_bad: cover property (done && type_bad);
endmodule
bind dsc_packed_codec dsc_codec_sva u_sva (.*);

// ---- bench/dsc_mem_model.sv ----
`timescale 1ns/1ps
module dsc_mem_model (
  // Clock
  input wire clk_sys,
  // Byte port
  input wire [15:0] mem_addr,
  input wire mem_rd,
  input wire mem_wr,
  input wire mem_word,
  input wire [15:0] mem_wdata,
  output wire [15:0] mem_rdata
);
  reg [7:0] m [0:65535];
  reg [15:0] junk_r = 16'h5a5a;
  // Read data stand only while the read strobe does; otherwise the lines show changing junk.
  assign mem_rdata = !mem_rd ? junk_r :
    (mem_word ? {m[mem_addr + 16'h1], m[mem_addr]} : {8'h00, m[mem_addr]});
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      m[mem_addr] <= mem_wdata[7:0];
    end
    junk_r <= ~junk_r;
  end
endmodule

// ---- bench/dsc_packed_codec_tb.sv ----
`timescale 1ns/1ps
module dsc_packed_codec_tb;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg cmd_valid = 1'b0;
  reg [1:0] cmd_op = 2'h0;
  reg inline_form = 1'b0;
  reg [15:0] reg_word0 = 16'h0, reg_word1 = 16'h0, desc_ptr = 16'h0;
  reg [127:0] res_digits = 128'h0;
  reg res_neg = 1'b0;
  wire [15:0] mem_addr, mem_wdata, mem_rdata;
  wire mem_rd, mem_wr, mem_word, busy, done, src_neg, src_zero, overflow, type_bad;
  wire [127:0] src_digits;
  wire [4:0] desc_len;
  wire [2:0] desc_type;
  integer err_count = 0, n_checks = 0, i, k, sd;
  reg [31:0] seed = 32'hd3a4, r;
  reg [127:0] dg;
  reg [4:0] ln;
  reg [2:0] ty;
  reg [3:0] sg;
  reg [15:0] ad;
  reg ng, ov;
  always #12.5 clk_sys = ~clk_sys;
  dsc_packed_codec u_dut (.*);
  dsc_mem_model u_mem (.*);
  function [31:0] rnd(input integer d);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [3:0] nib(input integer n);
    begin
      if (n == 0) nib = sg;
      else nib = n <= ln ? dg[4 * n - 4 +: 4] : 4'h0;
    end
  endfunction
  task chk(input [127:0] got, input [127:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // With dbl set, a second cycle of cmd_valid lands while busy and must be ignored.
  task op(input [1:0] o, input dbl, input inl);
    integer t;
    reg [15:0] w0, p;
    begin
      w0 = {1'b0, ty, 7'h0, ln};
      p = {4'h8, seed[11:1], 1'b0};
      {u_mem.m[p + 1], u_mem.m[p]} = w0;
      {u_mem.m[p + 3], u_mem.m[p + 2]} = ad;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_op <= o;
      inline_form <= inl;
      reg_word0 <= inl ? ~w0 : w0;
      reg_word1 <= inl ? ~ad : ad;
      desc_ptr <= p;
      res_digits <= dg;
      res_neg <= ng;
      @(posedge clk_sys);
      cmd_valid <= dbl;
      cmd_op <= dbl ? ~o : o;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 200) begin
        @(posedge clk_sys);
        #1;
        t = t + 1;
      end
      chk(t < 200, 1);
      chk({busy, done}, 2'b01);
    end
  endtask
  initial begin
    #250000;
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (i = 0; i < 64; i = i + 1) begin
      r = rnd(0);
      ln = i < 2 ? 5'd0 : (i < 4 ? 5'd31 : r[4:0]);
      ty = (i % 8 == 4) ? r[7:5] % 3'd6 : {2'b11, r[8]};
      sd = r[14:9] % 33;
      ng = r[15];
      sg = ty[0] ? 4'hf : 4'ha + r[18:16] % 3'd6;
      ad = {4'h1, r[30:19]};
      for (k = 0; k < 32; k = k + 1) dg[4 * k +: 4] = k < sd ? rnd(0) % 10 : 4'h0;
      if (!i[0]) begin
        dg = dg & ~({128{1'b1}} << 4 * ln);
        for (k = 0; k <= ln / 2; k = k + 1) u_mem.m[ad + ln / 2 - k] = {nib(2 * k + 1), nib(2 * k)};
        op(2'h0, r[31], rnd(0) & 1);
        chk(type_bad, ty[2:1] != 2'b11);
        chk(desc_len, ln);
        chk(desc_type, ty);
        if (ty[2:1] == 2'b11) begin
          chk(src_digits, dg);
          chk(src_zero, dg == 0);
          chk(src_neg, !ty[0] && (sg == 4'hb || sg == 4'hd) && dg != 0);
        end
      end else begin
        ov = (dg >> 4 * ln) != 0;
        sg = ty[0] ? 4'hf : (ng && dg != 0 ? 4'hd : 4'hc);
        op(2'h1, r[31], rnd(0) & 1);
        chk(overflow, ov);
        for (k = 0; k <= ln / 2; k = k + 1) chk(u_mem.m[ad + ln / 2 - k], {nib(2 * k + 1), nib(2 * k)});
      end
    end
    conclude;
  end
endmodule

// ---- logic/dsc_defines.vh ----
`ifndef DSC_DEFINES_VH
`define DSC_DEFINES_VH

// Descriptor field positions.
`define DSC_LEN_MSB 4
`define DSC_LEN_LSB 0
`define DSC_TYPE_MSB 14
`define DSC_TYPE_LSB 12
`define DSC_MAX_DIGITS 5'd31

// Data type codes.
`define DSC_T_ZONED_S 3'h0
`define DSC_T_ZONED_U 3'h1
`define DSC_T_OVP_TRAIL 3'h2
`define DSC_T_OVP_LEAD 3'h3
`define DSC_T_SEP_TRAIL 3'h4
`define DSC_T_SEP_LEAD 3'h5
`define DSC_T_PACK_S 3'h6
`define DSC_T_PACK_U 3'h7

// Sign nibbles.
`define DSC_SGN_POS 4'hc
`define DSC_SGN_NEG 4'hd
`define DSC_SGN_POS_A1 4'ha
`define DSC_SGN_POS_A2 4'he
`define DSC_SGN_NEG_A 4'hb
`define DSC_SGN_UNS 4'hf

// Operation codes on the command port.
`define DSC_OP_LOAD 2'h0
`define DSC_OP_STORE 2'h1

`endif

// ---- logic/dsc_desc_decode.v ----
`timescale 1ns/1ps
`include "dsc_defines.vh"

// Splits a two-word descriptor into length, type, address and byte count.
module dsc_desc_decode (
  // Descriptor words
  input wire [15:0] word0,
  input wire [15:0] word1,
  input wire packed_class,
  // Decoded fields
  output wire [4:0] len,
  output wire [2:0] dtype,
  output wire [15:0] addr,
  output wire [4:0] nbytes,
  output wire type_ok
);
  assign len = word0[`DSC_LEN_MSB:`DSC_LEN_LSB];
  assign dtype = word0[`DSC_TYPE_MSB:`DSC_TYPE_LSB];
  assign addr = word1;
  assign nbytes = {1'b0, len[4:1]} + 5'h01;
  // Reserved codes are flagged only; behaviour with them is left open.
  assign type_ok = packed_class ? (dtype[2:1] == 2'b11) : (dtype[2:1] != 2'b11);
endmodule

// ---- logic/dsc_packed_codec.v ----
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "dsc_defines.vh"

// How it works
// - Strings hold 0 to 31 digits in whole bytes, signed or unsigned.
// - Each digit is a four-bit binary nibble, 0000 through 1001.
// - Source strings are not checked; invalid encodings give unpredictable results.
// - Zero magnitude reads alike for any sign; zero results are stored positive.
// - Spare leading destination digits are written as zero.
// - Digits that do not fit are dropped and decimal overflow is raised.
// - Overflow of a negative result with no digit kept stores negative zero.
// - Zero-length destination stores no digits; packed keeps sign; nonzero overflows.
// - Each operand may use any type of its class independently.
// - A descriptor is two words, from registers or from memory.
// - Digit count is bits 4 to 0 of word one, unsigned.
// - Type is bits 14 to 12; word two is the top digit's byte address.
// - Numeric types: 000 to 101 defined, 110 and 111 reserved.
// - Packed types: 110 signed, 111 unsigned, the rest reserved.
// - Last byte holds the sign low and the lowest digit high.
// - Signed packed reads c,a,e,f positive and d,b negative; writes c or d.
// - Unsigned packed uses sign nibble f both ways.
// - Other bytes keep the higher digit high; odd length starts high.
// - Even length starts low in the first byte; its high nibble is zero.
// - Byte count is digit count divided by two plus one.
// - Zero length packed is one byte: zero high nibble, sign low.
module dsc_packed_codec (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Command from instruction sequencing
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire inline_form,
  input wire [15:0] reg_word0,
  input wire [15:0] reg_word1,
  input wire [15:0] desc_ptr,
  input wire [127:0] res_digits,
  input wire res_neg,
  // Memory byte port, read data returned in the cycle the read strobe stands
  output reg [15:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg mem_word,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  // Results
  output reg busy,
  output reg done,
  output reg [127:0] src_digits,
  output reg src_neg,
  output reg src_zero,
  output reg overflow,
  output reg type_bad,
  output reg [4:0] desc_len,
  output reg [2:0] desc_type
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DW0 = 3'h1;
  localparam ST_DW1 = 3'h2;
  localparam ST_DW1W = 3'h3;
  localparam ST_GO = 3'h4;
  localparam ST_RD = 3'h5;
  localparam ST_WR = 3'h6;
  localparam ST_END = 3'h7;

  reg [2:0] st_r;
  reg op_store_r;
  reg [15:0] w0_r;
  reg [15:0] w1_r;
  reg [4:0] idx_r;
  reg [127:0] dig_r;
  reg neg_r;
  reg ovf_r;

  wire [4:0] d_len;
  wire [2:0] d_type;
  wire [15:0] d_addr;
  wire [4:0] d_nbytes;
  wire d_ok;
  wire [3:0] s_nib;
  wire s_neg;
  wire [3:0] w_nib;

  dsc_desc_decode u_dec (
    .word0(w0_r),
    .word1(w1_r),
    .packed_class(1'b1),
    .len(d_len),
    .dtype(d_type),
    .addr(d_addr),
    .nbytes(d_nbytes),
    .type_ok(d_ok)
  );

  // Digit nibble n, counted from the least significant digit.
  function [3:0] dig_at;
    input [127:0] v;
    input [5:0] n;
    begin
      dig_at = v[{n[4:0], 2'b00} +: 4];
    end
  endfunction

  // Result digits above the destination length, used for overflow.
  function lost_digits;
    input [127:0] v;
    input [4:0] len;
    integer k;
    begin
      lost_digits = 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        if (k >= len && v[4*k +: 4] != 4'h0) begin
          lost_digits = 1'b1;
        end
      end
    end
  endfunction

  // Digits within the destination length, all zero after truncation.
  function kept_zero;
    input [127:0] v;
    input [4:0] len;
    integer k;
    begin
      kept_zero = 1'b1;
      for (k = 0; k < 32; k = k + 1) begin
        if (k < len && v[4*k +: 4] != 4'h0) begin
          kept_zero = 1'b0;
        end
      end
    end
  endfunction

  // Byte index b from the low address; digit positions of its two nibbles.
  // For byte b the high nibble holds digit 2*(nbytes-1-b), the low nibble one less.
  wire [4:0] byte_from_end = d_nbytes - 5'h01 - idx_r;
  wire [5:0] hi_pos = {byte_from_end, 1'b0};
  wire [5:0] lo_pos = {byte_from_end, 1'b0} - 6'h01;
  wire last_byte = (idx_r == d_nbytes - 5'h01);
  wire is_uns = (d_type == `DSC_T_PACK_U);
  // Positions at or above the length are fill and read as zero.
  wire [3:0] rd_hi_nib = mem_rdata[7:4];
  wire [3:0] rd_lo_nib = mem_rdata[3:0];
  assign s_nib = rd_lo_nib;

  dsc_sign_code u_sgn (
    .src_nib(s_nib),
    .src_unsigned(is_uns),
    .src_neg(s_neg),
    .res_neg(neg_r),
    .dst_unsigned(is_uns),
    .dst_nib(w_nib)
  );

  // Write byte assembly: fill positions beyond the length with zero.
  wire [5:0] len6 = {1'b0, d_len};
  wire [3:0] wr_hi = (hi_pos < len6) ? dig_at(dig_r, hi_pos) : 4'h0;
  wire [3:0] wr_lo = (lo_pos < len6) ? dig_at(dig_r, lo_pos) : 4'h0;
  wire [7:0] wr_byte = last_byte ? {wr_hi, w_nib} : {wr_hi, wr_lo};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      op_store_r <= 1'b0;
      w0_r <= 16'h0000;
      w1_r <= 16'h0000;
      idx_r <= 5'h00;
      dig_r <= 128'h0;
      neg_r <= 1'b0;
      ovf_r <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_word <= 1'b0;
      mem_wdata <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      src_digits <= 128'h0;
      src_neg <= 1'b0;
      src_zero <= 1'b1;
      overflow <= 1'b0;
      type_bad <= 1'b0;
      desc_len <= 5'h00;
      desc_type <= 3'h0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      done <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (cmd_valid) begin
            busy <= 1'b1;
            op_store_r <= (cmd_op == `DSC_OP_STORE);
            dig_r <= res_digits;
            neg_r <= res_neg;
            idx_r <= 5'h00;
            if (inline_form) begin
              mem_addr <= desc_ptr;
              mem_rd <= 1'b1;
              mem_word <= 1'b1;
              st_r <= ST_DW0;
            end else begin
              w0_r <= reg_word0;
              w1_r <= reg_word1;
              st_r <= ST_GO;
            end
          end
        end
        ST_DW0: begin
          w0_r <= mem_rdata;
          mem_addr <= mem_addr + 16'h0002;
          mem_rd <= 1'b1;
          st_r <= ST_DW1;
        end
        ST_DW1: begin
          w1_r <= mem_rdata;
          st_r <= ST_DW1W;
        end
        ST_DW1W: begin
          st_r <= ST_GO;
        end
        ST_GO: begin
          // Either packed type may serve any operand of a packed command.
          desc_len <= d_len;
          desc_type <= d_type;
          type_bad <= !d_ok;
          mem_word <= 1'b0;
          mem_addr <= d_addr;
          if (op_store_r) begin
            // Sign is forced positive when the kept digits are all zero,
            // unless overflow took nonzero digits away from a negative result.
            ovf_r <= lost_digits(dig_r, d_len);
            neg_r <= neg_r && !is_uns && (!kept_zero(dig_r, d_len) ||
              lost_digits(dig_r, d_len));
            st_r <= ST_WR;
          end else begin
            src_digits <= 128'h0;
            mem_rd <= 1'b1;
            st_r <= ST_RD;
          end
        end
        ST_RD: begin
          // Read data of the byte addressed in this cycle stands now; no validation.
          if (hi_pos < len6) begin
            src_digits[{hi_pos[4:0], 2'b00} +: 4] <= rd_hi_nib;
          end
          if (!last_byte && lo_pos < len6) begin
            src_digits[{lo_pos[4:0], 2'b00} +: 4] <= rd_lo_nib;
          end
          if (last_byte) begin
            src_neg <= s_neg;
            st_r <= ST_END;
          end else begin
            idx_r <= idx_r + 5'h01;
            mem_addr <= mem_addr + 16'h0001;
            mem_rd <= 1'b1;
          end
        end
        ST_WR: begin
          mem_wr <= 1'b1;
          mem_wdata <= {8'h00, wr_byte};
          if (idx_r != 5'h00) begin
            mem_addr <= mem_addr + 16'h0001;
          end
          if (last_byte) begin
            st_r <= ST_END;
          end else begin
            idx_r <= idx_r + 5'h01;
          end
        end
        ST_END: begin
          if (!op_store_r) begin
            // Zero magnitude reads as positive whatever its sign nibble.
            src_zero <= (src_digits == 128'h0);
            src_neg <= src_neg && (src_digits != 128'h0);
          end
          overflow <= op_store_r && ovf_r;
          busy <= 1'b0;
          done <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- logic/dsc_sign_code.v ----
`timescale 1ns/1ps
`include "dsc_defines.vh"

// Sign nibble decode for sources and encode for destinations.
module dsc_sign_code (
  // Source side
  input wire [3:0] src_nib,
  input wire src_unsigned,
  output wire src_neg,
  // Destination side
  input wire res_neg,
  input wire dst_unsigned,
  output wire [3:0] dst_nib
);
  // Unsigned strings are never negative; signed accept preferred and alternates.
  assign src_neg = !src_unsigned &&
    (src_nib == `DSC_SGN_NEG || src_nib == `DSC_SGN_NEG_A);
  assign dst_nib = dst_unsigned ? `DSC_SGN_UNS :
    (res_neg ? `DSC_SGN_NEG : `DSC_SGN_POS);
endmodule
